// ### inc/irq_ctrl_regs.svh
// Register indices, field positions, reset values and codes of the interrupt enable and request block.
// Assumes AXI4-Lite byte address = 4 * index, data in the low byte of each word.
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH
`define IDX_EDGE_SEL     8'hBF
`define IDX_HI_FLAGS     8'hC6
`define IDX_HI_ENABLES   8'hC7
`define IDX_MAIN_FLAGS   8'hC8
`define IDX_MAIN_ENABLES 8'hC9
`define IDX_STACK_GIE    8'hDF
`define IDX_EVT_STATUS   8'hE0
`define IDX_EVT_MASK     8'hE1
`define MAIN_IMPL_MASK   8'hF7
`define HI_IMPL_MASK     8'h03
`define EDGE_IMPL_MASK   8'h3F
`define EVT_IMPL_MASK    8'h0F
`define GIE_BIT          7
`define BIT_BASE_TIMER   4
`define BIT_TC_ZERO      5
`define BIT_TC_ONE       6
`define BIT_CONVERTER    7
`define BIT_TC_TWO       0
`define BIT_TC_THREE     1
`define SP_RESET         3'h7
`define SP_BOTTOM        3'h0
`define SP_STEP          3'h1
`define VECTOR_ADDR      12'h008
`define EDGE_RISE        2'h1
`define EDGE_FALL        2'h2
`define EDGE_BOTH        2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`define EVT_TAKEN        0
`define EVT_RETURN       1
`define EVT_OVERFLOW     2
`define EVT_UNDERFLOW    3
`endif

// ### inc/irq_ctrl_pkg.sv
// Types shared by the interrupt enable and request block.
// Assumes irq_ctrl_regs.svh supplies the numeric constants.
`default_nettype none
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_SERVICE = 2'h1
  } irq_state_type;
  typedef enum logic [2:0] {
    SEL_NONE, SEL_EDGE, SEL_HI_FLAGS, SEL_HI_EN, SEL_MAIN_FLAGS,
    SEL_MAIN_EN, SEL_STACK, SEL_EVT_STATUS
  } reg_sel_type;
endpackage
`default_nettype wire

// ### verilog/irq_ctrl.sv
// Interrupt enable, request flags, global enable and vectoring for an 8-bit core.
// Assumes the core pulses INSN_BOUNDARY and RETURN_FROM_INTERRUPT on REF_CLK.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.svh"
module irq_ctrl (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  input  wire logic [2:0]  EXT_IN,
  input  wire logic        BASE_TIMER_EVT,
  input  wire logic        TMR_CNT_ZERO_EVT,
  input  wire logic        TMR_CNT_ONE_EVT,
  input  wire logic        CONVERTER_EVT,
  input  wire logic        TMR_CNT_TWO_EVT,
  input  wire logic        TMR_CNT_THREE_EVT,
  input  wire logic        INSN_BOUNDARY,
  input  wire logic        RETURN_FROM_INTERRUPT,
  input  wire logic [11:0] NEXT_PC,
  output logic             VECTOR_REQ,
  output logic             PC_LOAD,
  output logic [11:0]      PC_TARGET,
  output logic             IRQ_OUT
);

  function automatic irq_ctrl_pkg::reg_sel_type reg_sel(input logic [11:0] a);
    if (a[11:2] == {2'h0, `IDX_EDGE_SEL}) begin
      reg_sel = irq_ctrl_pkg::SEL_EDGE;
    end else if (a[11:2] == {2'h0, `IDX_HI_FLAGS}) begin
      reg_sel = irq_ctrl_pkg::SEL_HI_FLAGS;
    end else if (a[11:2] == {2'h0, `IDX_HI_ENABLES}) begin
      reg_sel = irq_ctrl_pkg::SEL_HI_EN;
    end else if (a[11:2] == {2'h0, `IDX_MAIN_FLAGS}) begin
      reg_sel = irq_ctrl_pkg::SEL_MAIN_FLAGS;
    end else if (a[11:2] == {2'h0, `IDX_MAIN_ENABLES}) begin
      reg_sel = irq_ctrl_pkg::SEL_MAIN_EN;
    end else if (a[11:2] == {2'h0, `IDX_STACK_GIE}) begin
      reg_sel = irq_ctrl_pkg::SEL_STACK;
    end else if (a[11:2] == {2'h0, `IDX_EVT_STATUS}) begin
      reg_sel = irq_ctrl_pkg::SEL_EVT_STATUS;
    end else begin
      reg_sel = irq_ctrl_pkg::SEL_NONE;
    end
  endfunction

  // Mask register has no enum slot; decoded separately
  function automatic logic is_mask(input logic [11:0] a);
    is_mask = (a[11:2] == {2'h0, `IDX_EVT_MASK});
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = ((sel == `EDGE_RISE) && rise) ||
               ((sel == `EDGE_FALL) && fall) ||
               ((sel == `EDGE_BOTH) && (rise || fall));
  endfunction

  // Bus state
  logic        aw_full_reg, aw_full_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic        w_full_reg, w_full_next;
  logic [7:0]  w_data_reg, w_data_next;
  logic        w_lane_reg, w_lane_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic [1:0]  rresp_reg, rresp_next;
  // Register file
  logic [7:0]  edge_sel_reg, edge_sel_next;
  logic [7:0]  main_en_reg, main_en_next;
  logic [7:0]  hi_en_reg, hi_en_next;
  logic [7:0]  main_flags_reg, main_flags_next;
  logic [7:0]  hi_flags_reg, hi_flags_next;
  logic        gie_reg, gie_next;
  logic [2:0]  sp_reg, sp_next;
  logic [7:0]  evt_status_reg, evt_status_next;
  logic [7:0]  evt_mask_reg, evt_mask_next;
  logic        irq_reg, irq_next;
  // Vectoring
  irq_ctrl_pkg::irq_state_type state_reg, state_next;
  logic        pc_load_reg, pc_load_next;
  logic [11:0] pc_target_reg, pc_target_next;
  logic [11:0] ret_stack [0:7];
  // Pin sampling
  logic [2:0]  ext_meta_reg, ext_sync_reg, ext_prev_reg;
  logic        wr_fire, rd_fire, wr_en, take, give_back, pending;
  logic [2:0]  ext_hit;
  logic [7:0]  main_set, hi_set, evt_set;
  irq_ctrl_pkg::reg_sel_type wr_sel, rd_sel;
  assign AWREADY = !aw_full_reg;
  assign WREADY  = !w_full_reg;
  assign ARREADY = !rvalid_reg;
  assign BVALID  = bvalid_reg;
  assign BRESP   = bresp_reg;
  assign RVALID  = rvalid_reg;
  assign RRESP   = rresp_reg;
  assign RDATA   = {24'h000000, rdata_reg};
  assign PC_LOAD   = pc_load_reg;
  assign PC_TARGET = pc_target_reg;
  assign IRQ_OUT   = irq_reg;
  // Response waits for both address and data; one write outstanding
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign rd_fire = ARVALID && !rvalid_reg;
  assign wr_sel  = reg_sel(aw_addr_reg);
  assign rd_sel  = reg_sel(ARADDR);
  assign wr_en   = wr_fire && w_lane_reg;
  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_lane_next  = w_lane_reg;
    bvalid_next  = bvalid_reg && !BREADY;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg && !RREADY;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (AWVALID && !aw_full_reg) begin
      aw_full_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    if (WVALID && !w_full_reg) begin
      w_full_next = 1'b1;
      w_data_next = WDATA[7:0];
      w_lane_next = WSTRB[0];
    end
    if (wr_fire) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = (wr_sel == irq_ctrl_pkg::SEL_NONE && !is_mask(aw_addr_reg)) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = `RESP_OKAY;
      if (rd_sel == irq_ctrl_pkg::SEL_EDGE) begin
        rdata_next = edge_sel_reg;
      end else if (rd_sel == irq_ctrl_pkg::SEL_HI_FLAGS) begin
        rdata_next = hi_flags_reg;
      end else if (rd_sel == irq_ctrl_pkg::SEL_HI_EN) begin
        rdata_next = hi_en_reg;
      end else if (rd_sel == irq_ctrl_pkg::SEL_MAIN_FLAGS) begin
        rdata_next = main_flags_reg;
      end else if (rd_sel == irq_ctrl_pkg::SEL_MAIN_EN) begin
        rdata_next = main_en_reg;
      end else if (rd_sel == irq_ctrl_pkg::SEL_STACK) begin
        rdata_next = {gie_reg, 4'h0, sp_reg};
      end else if (rd_sel == irq_ctrl_pkg::SEL_EVT_STATUS) begin
        rdata_next = evt_status_reg;
      end else if (is_mask(ARADDR)) begin
        rdata_next = evt_mask_reg;
      end else begin
        rdata_next = 8'h00;
        rresp_next = `RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 8'h00;
      rresp_reg   <= `RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_lane_reg  <= w_lane_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Pins are asynchronous; edge detection only after the second stage
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ext_meta_reg <= 3'h0;
      ext_sync_reg <= 3'h0;
      ext_prev_reg <= 3'h0;
    end else begin
      ext_meta_reg <= EXT_IN;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      ext_hit[i] = edge_hit(edge_sel_reg[2*i +: 2], ext_sync_reg[i] && !ext_prev_reg[i],
                            !ext_sync_reg[i] && ext_prev_reg[i]) && main_en_reg[i];
    end
  end

  always_comb begin
    main_set = {5'h00, ext_hit};
    main_set[`BIT_BASE_TIMER] = BASE_TIMER_EVT;
    main_set[`BIT_TC_ZERO]    = TMR_CNT_ZERO_EVT;
    main_set[`BIT_TC_ONE]     = TMR_CNT_ONE_EVT;
    main_set[`BIT_CONVERTER]  = CONVERTER_EVT;
    hi_set = 8'h00;
    hi_set[`BIT_TC_TWO]   = TMR_CNT_TWO_EVT;
    hi_set[`BIT_TC_THREE] = TMR_CNT_THREE_EVT;
  end
  // Global enable gates the OR of enabled flags
  assign pending    = gie_reg && (|(main_flags_reg & main_en_reg) || |(hi_flags_reg & hi_en_reg));
  assign VECTOR_REQ = pending;
  assign take       = (state_reg == irq_ctrl_pkg::ST_IDLE) && INSN_BOUNDARY && pending;
  assign give_back  = (state_reg == irq_ctrl_pkg::ST_SERVICE) && RETURN_FROM_INTERRUPT;
  always_comb begin
    evt_set = 8'h00;
    evt_set[`EVT_TAKEN]     = take;
    evt_set[`EVT_RETURN]    = give_back;
    evt_set[`EVT_OVERFLOW]  = take && (sp_reg == `SP_BOTTOM);
    evt_set[`EVT_UNDERFLOW] = give_back && (sp_reg == `SP_RESET);
  end

  always_comb begin
    edge_sel_next   = edge_sel_reg;
    main_en_next    = main_en_reg;
    hi_en_next      = hi_en_reg;
    main_flags_next = main_flags_reg;
    hi_flags_next   = hi_flags_reg;
    gie_next        = gie_reg;
    sp_next         = sp_reg;
    evt_status_next = evt_status_reg;
    evt_mask_next   = evt_mask_reg;
    state_next      = state_reg;
    pc_load_next    = 1'b0;
    pc_target_next  = pc_target_reg;
    if (wr_en) begin
      if (wr_sel == irq_ctrl_pkg::SEL_EDGE) begin
        edge_sel_next = w_data_reg & `EDGE_IMPL_MASK;
      end else if (wr_sel == irq_ctrl_pkg::SEL_HI_FLAGS) begin
        hi_flags_next = w_data_reg & `HI_IMPL_MASK;
      end else if (wr_sel == irq_ctrl_pkg::SEL_HI_EN) begin
        hi_en_next = w_data_reg & `HI_IMPL_MASK;
      end else if (wr_sel == irq_ctrl_pkg::SEL_MAIN_FLAGS) begin
        main_flags_next = w_data_reg & `MAIN_IMPL_MASK;
      end else if (wr_sel == irq_ctrl_pkg::SEL_MAIN_EN) begin
        main_en_next = w_data_reg & `MAIN_IMPL_MASK;
      end else if (wr_sel == irq_ctrl_pkg::SEL_STACK) begin
        gie_next = w_data_reg[`GIE_BIT];
        sp_next  = w_data_reg[2:0];
      end else if (wr_sel == irq_ctrl_pkg::SEL_EVT_STATUS) begin
        evt_status_next = evt_status_reg & ~w_data_reg;
      end else if (is_mask(aw_addr_reg)) begin
        evt_mask_next = w_data_reg & `EVT_IMPL_MASK;
      end
    end
    // A request in the same cycle as a clear still lands
    main_flags_next = main_flags_next | main_set;
    hi_flags_next   = hi_flags_next | hi_set;
    evt_status_next = evt_status_next | evt_set;
    // Core sequencing overrides a software write in the same cycle
    case (state_reg)
      irq_ctrl_pkg::ST_IDLE: begin
        if (take) begin
          gie_next       = 1'b0;
          sp_next        = sp_reg - `SP_STEP;
          pc_load_next   = 1'b1;
          pc_target_next = `VECTOR_ADDR;
          state_next     = irq_ctrl_pkg::ST_SERVICE;
        end
      end
      irq_ctrl_pkg::ST_SERVICE: begin
        if (give_back) begin
          gie_next       = 1'b1;
          sp_next        = sp_reg + `SP_STEP;
          pc_load_next   = 1'b1;
          pc_target_next = ret_stack[sp_reg + `SP_STEP];
          state_next     = irq_ctrl_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = irq_ctrl_pkg::ST_IDLE;
      end
    endcase
    irq_next = |(evt_status_next & evt_mask_next);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      edge_sel_reg   <= 8'h00;
      main_en_reg    <= 8'h00;
      hi_en_reg      <= 8'h00;
      main_flags_reg <= 8'h00;
      hi_flags_reg   <= 8'h00;
      gie_reg        <= 1'b0;
      sp_reg         <= `SP_RESET;
      evt_status_reg <= 8'h00;
      evt_mask_reg   <= 8'h00;
      irq_reg        <= 1'b0;
      state_reg      <= irq_ctrl_pkg::ST_IDLE;
      pc_load_reg    <= 1'b0;
      pc_target_reg  <= 12'h000;
    end else begin
      edge_sel_reg   <= edge_sel_next;
      main_en_reg    <= main_en_next;
      hi_en_reg      <= hi_en_next;
      main_flags_reg <= main_flags_next;
      hi_flags_reg   <= hi_flags_next;
      gie_reg        <= gie_next;
      sp_reg         <= sp_next;
      evt_status_reg <= evt_status_next;
      evt_mask_reg   <= evt_mask_next;
      irq_reg        <= irq_next;
      state_reg      <= state_next;
      pc_load_reg    <= pc_load_next;
      pc_target_reg  <= pc_target_next;
    end
  end

  // Return stack is plain storage; no reset needed, the pointer guards it
  always_ff @(posedge REF_CLK) begin
    if (take) begin
      ret_stack[sp_reg] <= NEXT_PC;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  vector_jump_a: assert property (take |=> PC_LOAD && PC_TARGET == `VECTOR_ADDR)
    else $error("interrupt entry did not load the vector");
  stack_push_a: assert property (take |=> sp_reg == $past(sp_reg) - `SP_STEP)
    else $error("interrupt entry did not push the stack");
  return_pop_a: assert property (give_back |=> PC_LOAD && sp_reg == $past(sp_reg) + `SP_STEP)
    else $error("return did not pop the stack");
  entry_gie_a: assert property (take |=> !gie_reg && state_reg == irq_ctrl_pkg::ST_SERVICE)
    else $error("global enable not cleared on entry");
  return_gie_a: assert property (give_back |=> gie_reg && state_reg == irq_ctrl_pkg::ST_IDLE)
    else $error("global enable not restored on return");
  global_gate_a: assert property (!gie_reg |-> !VECTOR_REQ && !take)
    else $error("request raised with global enable off");
  source_gate_a: assert property (VECTOR_REQ |-> |({main_flags_reg, hi_flags_reg} & {main_en_reg, hi_en_reg}))
    else $error("request raised with no enabled flag");
  flag_sticky_a: assert property (BASE_TIMER_EVT |=> main_flags_reg[`BIT_BASE_TIMER] [*2])
    else $error("base timer flag not set or not held");
  ext_disabled_a: assert property ((!main_en_reg[0] && !(wr_en && wr_sel == irq_ctrl_pkg::SEL_MAIN_FLAGS))
                                   |=> !$rose(main_flags_reg[0]))
    else $error("disabled external input set its flag");

endmodule // irq_ctrl
`default_nettype wire

// ### verification/core_src_model.sv
// Model of the processor core and the six on-chip request sources.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module core_src_model (
  input  wire logic        clk,
  input  wire logic        pc_load,
  input  wire logic [11:0] pc_target,
  output logic [5:0]       evt,
  output logic             boundary,
  output logic             rfi,
  output logic [11:0]      next_pc
);
  initial begin
    evt = 6'h00;
    boundary = 1'b0;
    rfi = 1'b0;
    next_pc = 12'h000;
  end
  // One-cycle request from source n
  task automatic pulse(input int n);
    evt <= 6'h01 << n;
    @(posedge clk);
    evt <= 6'h00;
  endtask
  // No fixed latency assumed for the load strobe
  task automatic get_load(output logic [11:0] tgt);
    logic hit;
    hit = 1'b0;
    while (!hit) begin
      #1;
      hit = pc_load;
      tgt = pc_target;
      @(posedge clk);
    end
  endtask
  // Delay before the boundary lets the model act as a slow core
  task automatic take(input int slow, input logic [11:0] pc, output logic [11:0] tgt);
    repeat (slow) @(posedge clk);
    boundary <= 1'b1;
    next_pc <= pc;
    @(posedge clk);
    boundary <= 1'b0;
    // Scrambled so a saved address cannot come from the live bus
    next_pc <= ~pc;
    get_load(tgt);
  endtask
  task automatic ret(output logic [11:0] tgt);
    rfi <= 1'b1;
    @(posedge clk);
    rfi <= 1'b0;
    get_load(tgt);
  endtask
endmodule // core_src_model
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for irq_ctrl over AXI4-Lite and the core interface.
// Assumes core_src_model stands in for the core and the request sources.
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.svh"
module tb_top;
  logic        ref_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        vector_req, pc_load, irq_out, boundary, rfi;
  logic [11:0] awaddr, araddr, pc_target, next_pc, tgt;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  ext_in;
  logic [5:0]  evt;
  logic [7:0]  ridx [4];
  logic [7:0]  rmsk [4];
  int          err_total, checks, i, md;

  irq_ctrl dut_u (
    .REF_CLK(ref_clk), .RST_B(rst_b), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
    .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .EXT_IN(ext_in), .BASE_TIMER_EVT(evt[0]),
    .TMR_CNT_ZERO_EVT(evt[1]), .TMR_CNT_ONE_EVT(evt[2]), .CONVERTER_EVT(evt[3]),
    .TMR_CNT_TWO_EVT(evt[4]), .TMR_CNT_THREE_EVT(evt[5]), .INSN_BOUNDARY(boundary),
    .RETURN_FROM_INTERRUPT(rfi), .NEXT_PC(next_pc), .VECTOR_REQ(vector_req), .PC_LOAD(pc_load),
    .PC_TARGET(pc_target), .IRQ_OUT(irq_out)
  );
  core_src_model m_u (
    .clk(ref_clk), .pc_load(pc_load), .pc_target(pc_target), .evt(evt),
    .boundary(boundary), .rfi(rfi), .next_pc(next_pc)
  );

  always #5 ref_clk = ~ref_clk;

  task automatic close_out();
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
    logic a_do, w_do, a_hit, w_hit, b_hit;
    a_do = 1'b0;
    w_do = 1'b0;
    b_hit = 1'b0;
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(a_do && w_do)) begin
      #1;
      a_hit = awvalid && awready;
      w_hit = wvalid && wready;
      @(posedge ref_clk);
      if (a_hit) begin
        a_do = 1'b1;
        awvalid <= 1'b0;
      end
      if (w_hit) begin
        w_do = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    while (!b_hit) begin
      #1;
      b_hit = bvalid;
      r = bresp;
      @(posedge ref_clk);
    end
    bready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [1:0] r;
    axw(idx, d, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic a_hit, r_hit;
    logic [31:0] d;
    logic [1:0] r;
    r_hit = 1'b0;
    araddr <= {2'h0, idx, 2'h0};
    arvalid <= 1'b1;
    while (!r_hit) begin
      #1;
      a_hit = arvalid && arready;
      r_hit = rvalid;
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (a_hit) arvalid <= 1'b0;
    end
    chk(d, {24'h0, exp});
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    close_out();
  end

  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    // Read data always accepted, so back-to-back reads never toggle rready
    {awvalid, wvalid, bready, arvalid, rready} = 5'h01;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    ext_in = 3'h0;
    err_total = 0;
    checks = 0;
    ridx = '{`IDX_MAIN_ENABLES, `IDX_HI_ENABLES, `IDX_MAIN_FLAGS, `IDX_HI_FLAGS};
    rmsk = '{8'hF7, 8'h03, 8'hF7, 8'h03};
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk({31'h0, vector_req}, 32'h0);
    rd_chk(`IDX_STACK_GIE, 8'h07);
    for (i = 0; i < 4; i++) begin
      rd_chk(ridx[i], 8'h00);
      wr(ridx[i], 8'hFF);
      rd_chk(ridx[i], rmsk[i]);
      wr(ridx[i], 8'h00);
      rd_chk(ridx[i], 8'h00);
    end
    axw(8'h00, 8'h5A, resp);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    // Low byte lane off: answered but not stored
    wstrb <= 4'h0;
    wr(`IDX_EDGE_SEL, 8'h15);
    wstrb <= 4'hF;
    rd_chk(`IDX_EDGE_SEL, 8'h00);
    // Each source lands in its own bit and stays there
    for (i = 0; i < 6; i++) begin
      m_u.pulse(i);
      repeat (3) @(posedge ref_clk);
      if (i < 4)
        rd_chk(`IDX_MAIN_FLAGS, 8'hF0 & ~(8'hE0 << i));
      else
        rd_chk(`IDX_HI_FLAGS, 8'h03 & ~(8'h02 << (i - 4)));
    end
    wr(`IDX_MAIN_FLAGS, 8'h00);
    wr(`IDX_HI_FLAGS, 8'h00);
    m_u.pulse(0);
    wr(`IDX_MAIN_ENABLES, 8'hEF);
    wr(`IDX_HI_ENABLES, 8'h03);
    wr(`IDX_STACK_GIE, 8'h87);
    chk({31'h0, vector_req}, 32'h0);
    wr(`IDX_MAIN_ENABLES, 8'h10);
    chk({31'h0, vector_req}, 32'h1);
    wr(`IDX_STACK_GIE, 8'h07);
    chk({31'h0, vector_req}, 32'h0);
    wr(`IDX_STACK_GIE, 8'h87);
    wr(`IDX_EVT_MASK, 8'h03);
    m_u.take(0, 12'h5A3, tgt);
    chk({20'h0, tgt}, 32'h008);
    rd_chk(`IDX_STACK_GIE, 8'h06);
    chk({31'h0, vector_req}, 32'h0);
    chk({31'h0, irq_out}, 32'h1);
    rd_chk(`IDX_MAIN_FLAGS, 8'h10);
    m_u.ret(tgt);
    chk({20'h0, tgt}, 32'h5A3);
    rd_chk(`IDX_STACK_GIE, 8'h87);
    rd_chk(`IDX_EVT_STATUS, 8'h03);
    wr(`IDX_EVT_STATUS, 8'h03);
    rd_chk(`IDX_EVT_STATUS, 8'h00);
    chk({31'h0, irq_out}, 32'h0);
    wr(`IDX_EVT_MASK, 8'h00);
    m_u.take(4, 12'hA5C, tgt);
    chk({20'h0, tgt}, 32'h008);
    rd_chk(`IDX_EVT_STATUS, 8'h01);
    chk({31'h0, irq_out}, 32'h0);
    m_u.ret(tgt);
    chk({20'h0, tgt}, 32'hA5C);
    // Push at pointer 000 wraps to 111; the pop from 111 must still return
    wr(`IDX_EVT_STATUS, 8'h0F);
    wr(`IDX_STACK_GIE, 8'h80);
    m_u.take(0, 12'h3C1, tgt);
    chk({20'h0, tgt}, 32'h008);
    rd_chk(`IDX_STACK_GIE, 8'h07);
    m_u.ret(tgt);
    chk({20'h0, tgt}, 32'h3C1);
    rd_chk(`IDX_EVT_STATUS, 8'h0F);
    wr(`IDX_MAIN_FLAGS, 8'h00);
    chk({31'h0, vector_req}, 32'h0);
    // Disabled input must ignore both edges
    wr(`IDX_MAIN_ENABLES, 8'h00);
    wr(`IDX_EDGE_SEL, 8'h3F);
    ext_in <= 3'h7;
    repeat (5) @(posedge ref_clk);
    ext_in <= 3'h0;
    repeat (5) @(posedge ref_clk);
    rd_chk(`IDX_MAIN_FLAGS, 8'h00);
    for (i = 0; i < 3; i++) begin
      for (md = 0; md < 4; md++) begin
        wr(`IDX_EDGE_SEL, 8'(md << (2 * i)));
        wr(`IDX_MAIN_ENABLES, 8'(1 << i));
        ext_in[i] <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_chk(`IDX_MAIN_FLAGS, md[0] ? 8'(1 << i) : 8'h00);
        wr(`IDX_MAIN_FLAGS, 8'h00);
        ext_in[i] <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rd_chk(`IDX_MAIN_FLAGS, md[1] ? 8'(1 << i) : 8'h00);
        wr(`IDX_MAIN_FLAGS, 8'h00);
      end
    end
    close_out();
  end
endmodule // tb_top
`default_nettype wire
